// *** osc_wdt_config_decode_tb.sv ***
// self-checking bench for the configuration decoder
`timescale 1ns/1ps
`default_nettype none
`include "owcd_consts.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module osc_wdt_config_decode_tb
  import owcd_pkg::*;
;
  logic aclk, aresetn, pll_locked, src_ready, slow;
  owcd_cfg_t nv_cfg;
  owcd_ctl_t ctl;
  logic [1:0] clk_state, s_axi_bresp, s_axi_rresp, resp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int num_errors, samples_checked, cyc;
  owcd_top i_dut (.*);
  owcd_osc_model i_osc (.aclk(aclk), .clk_state(clk_state), .slow(slow),
    .pll_locked(pll_locked), .src_ready(src_ready));
  always #10 aclk = ~aclk;
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel is released at its own handshake
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic rst;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : rst
  task wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // a hang counts as a mismatch
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aclk, aresetn, slow, cyc, num_errors, samples_checked} = '0;
    nv_cfg = {8'h01, 8'h83, 8'h85, 8'hDA};
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    rst;
    `CHK("wp", 1'b0, ctl.code_write_protect)
    `CHK("two", 1'b1, ctl.two_speed_startup_en)
    `CHK("src", OWCD_SRC_PRI_PLL, ctl.initial_osc_select)
    `CHK("pm", OWCD_POSC_XT, ctl.primary_osc_mode)
    `CHK("low_power_internal_rc", 1'b1, ctl.low_power_internal_rc_on)
    `CHK("post", 16'h0400, ctl.postscale_ratio)
    // switching disabled here, so every source code lands at once
    for (int i = 0; i < 8; i++) begin
      wr(`OWCD_ADDR_OSCSEL, 8'(i));
      `CHK("src", owcd_src_t'(i), ctl.initial_osc_select)
    end
    for (int i = 0; i < 4; i++) begin
      wr(`OWCD_ADDR_OSCCFG, {i[1:0], 3'h0, 1'b1, i[1:0]});
      `CHK("pm", owcd_posc_t'(i), ctl.primary_osc_mode)
      `CHK("sw", !i[1], ctl.switch_en)
      `CHK("mon", i == 0, ctl.monitor_en)
      `CHK("clko", !(i == 1 || i == 2), ctl.osc_out_clock)
    end
    wr(`OWCD_ADDR_OSCCFG, 8'hC0);
    `CHK("gpio", 1'b1, ctl.osc_out_gpio)
    // with switching on a new source must wait for reset
    wr(`OWCD_ADDR_OSCCFG, 8'h00);
    wr(`OWCD_ADDR_OSCSEL, 8'h05);
    `CHK("hold", OWCD_SRC_FRC_POST, ctl.initial_osc_select)
    wr(`OWCD_ADDR_OSCCFG, 8'h85);
    for (int i = 0; i < 16; i++) begin
      wr(`OWCD_ADDR_WDOG, {3'h2, i[0], i[3:0]});
      `CHK("post", 16'h0001 << i, ctl.postscale_ratio)
      `CHK("pre", i[0] ? 8'h80 : 8'h20, ctl.prescale_ratio)
      `CHK("win", 1'b0, ctl.wdog_window_mode)
    end
    `CHK("post15", 16'h8000, ctl.postscale_ratio)
    wr(`OWCD_ADDR_WDOG, 8'h20);
    `CHK("win", 1'b1, ctl.wdog_window_mode)
    `CHK("pllk", 1'b1, ctl.pll_lock_wait_en)
    wr(`OWCD_ADDR_SWCTL, 8'h00);
    `CHK("run", 1'b0, ctl.wdog_run)
    wr(`OWCD_ADDR_SWCTL, 8'h01);
    `CHK("run", 1'b1, ctl.wdog_run)
    wr(`OWCD_ADDR_WDOG, 8'h80);
    wr(`OWCD_ADDR_SWCTL, 8'h00);
    `CHK("run", 1'b1, ctl.wdog_run)
    rd(`OWCD_ADDR_STATUS);
    `CHK("stat", 2'h3, rdat[7:6])
    rd(8'h20);
    `CHK("resp", `OWCD_RESP_SLVERR, resp)
    wr(8'h20, 8'h00);
    `CHK("bresp", `OWCD_RESP_SLVERR, resp)
    rd(`OWCD_ADDR_WDOG);
    `CHK("rdw", 32'h00000080, rdat)
    wr(`OWCD_ADDR_SEGMENT, 8'h00);
    `CHK("wp", 1'b1, ctl.code_write_protect)
    // mid-run reset with a slow source and lock wait on
    slow <= 1'b1;
    nv_cfg.wdog_config_word <= 8'hFA;
    rst;
    `CHK("frc", OWCD_SRC_FRC, ctl.active_source)
    `CHK("src", OWCD_SRC_PRI_PLL, ctl.initial_osc_select)
    // slow lock keeps the sequencer parked in the lock state for a while
    repeat (3) @(posedge aclk);
    `CHK("lockw", 2'h1, clk_state)
    for (int n = 0; n < 100 && ctl.active_source != OWCD_SRC_PRI_PLL; n++)
      @(posedge aclk);
    `CHK("act", OWCD_SRC_PRI_PLL, ctl.active_source)
    wrap_up;
  end
endmodule : osc_wdt_config_decode_tb
`default_nettype wire

// *** owcd_chk.sv ***
// checker for the configuration decoder ports
`timescale 1ns/1ps
`default_nettype none
module owcd_chk
  import owcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire owcd_cfg_t nv_cfg,
  input wire logic pll_locked,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire owcd_ctl_t ctl,
  input wire logic [1:0] clk_state
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ctl is still cleared on the release edge, so skip that cycle
  logic up;
  always_ff @(posedge aclk) up <= aresetn;
  property p_load;
    $rose(aresetn) |=> ctl.primary_osc_mode == nv_cfg.osc_config_word[1:0]
      && ctl.prescale_ratio == (nv_cfg.wdog_config_word[4] ? 8'h80 : 8'h20);
  endproperty
  a_load: assert property (p_load) else $error("reload decode wrong");
  property p_pre;
    up |-> ctl.prescale_ratio inside {8'h80, 8'h20};
  endproperty
  a_pre: assert property (p_pre) else $error("bad prescale");
  property p_post;
    up |-> $onehot(ctl.postscale_ratio);
  endproperty
  a_post: assert property (p_post) else $error("bad postscale");
  property p_mon;
    ctl.monitor_en |-> ctl.switch_en;
  endproperty
  a_mon: assert property (p_mon) else $error("monitor alone");
  property p_pin;
    up && !(ctl.primary_osc_mode inside {OWCD_POSC_XT, OWCD_POSC_HS})
      |-> ctl.osc_out_clock != ctl.osc_out_gpio;
  endproperty
  a_pin: assert property (p_pin) else $error("pin function wrong");
  property p_lock;
    clk_state == 2'h1 |-> ctl.pll_lock_wait_en;
  endproperty
  a_lock: assert property (p_lock) else $error("lock wait unasked");
  property p_lock_exit;
    clk_state == 2'h1 && pll_locked |-> ##[1:3] clk_state != 2'h1;
  endproperty
  a_lock_exit: assert property (p_lock_exit) else $error("lock stuck");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  property p_rnext;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rnext: assert property (p_rnext) else $error("read answer late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
endmodule : owcd_chk
bind owcd_top owcd_chk i_chk (.*);
`default_nettype wire

// *** owcd_consts.svh ***
// constants for the oscillator and watchdog configuration decoder
// ---------------------------------------------------------------
// Summary of operation
// [R01] A code write-protect value of 1 leaves program memory writable, 0 blocks writes.
// [R02] Two-speed start-up 1 starts on the fast RC and switches to the chosen source when ready, 0 starts directly.
// [R03] The 3-bit initial source field selects one of eight clock sources.
// [R04] A new initial source takes effect at the next reset when switching is enabled, otherwise at once.
// [R05] The switching mode field enables clock switching and the fail-safe monitor as 1x none, 01 switch, 00 both.
// [R06] Outside the crystal modes the oscillator output pin is a clock output when its field is 1, else digital I/O.
// [R07] The 2-bit primary mode field selects disabled, high-speed crystal, standard crystal or external clock.
// [R08] Watchdog force enable 1 keeps the watchdog and low-power RC running whatever software does.
// [R09] Watchdog force enable 0 lets the software enable bit run or stop the watchdog and low-power RC.
// [R10] Window disable 1 selects non-window mode, 0 selects window mode.
// [R11] PLL lock wait 1 holds a switch to a PLL source until lock, 0 switches at once.
// [R12] Prescale select 1 gives 1:128, 0 gives 1:32.
// [R13] Postscaler code 1111 gives 1:32768 and 1110 gives 1:16384.
// [R14] Each lower postscaler code halves the ratio, down to 1:1 at code 0000.
// [R15] Fields load at reset and decoded outputs hold between reloads except for immediate writes.
// ---------------------------------------------------------------
`ifndef OWCD_CONSTS_SVH
`define OWCD_CONSTS_SVH
// AXI4-Lite byte offsets
`define OWCD_ADDR_SEGMENT 8'h00
`define OWCD_ADDR_OSCSEL 8'h04
`define OWCD_ADDR_OSCCFG 8'h08
`define OWCD_ADDR_WDOG 8'h0C
`define OWCD_ADDR_STATUS 8'h10
`define OWCD_ADDR_SWCTL 8'h14
// field positions in osc_select_word
`define OWCD_FNOSC_LSB 0
`define OWCD_TWO_SPEED_STARTUP_EN_BIT 7
// field positions in osc_config_word
`define OWCD_POSC_LSB 0
`define OWCD_OSCFN_BIT 2
`define OWCD_FCKSM_LSB 6
// field positions in wdog_config_word
`define OWCD_POST_LSB 0
`define OWCD_PRE_BIT 4
`define OWCD_WDOG_WINDOW_DISABLE_BIT 6
`define OWCD_WDOG_CONFIG_WORD_BIT 7
`define OWCD_PLLK_BIT 5
// axi responses
`define OWCD_RESP_OKAY 2'h0
`define OWCD_RESP_SLVERR 2'h2
// prescale ratios
`define OWCD_PRE_HI 8'h80
`define OWCD_PRE_LO 8'h20
`endif

// *** owcd_osc_model.sv ***
// oscillator source on the far side: settles a while after a switch
`timescale 1ns/1ps
`default_nettype none
module owcd_osc_model (
  input wire logic aclk,
  input wire logic [1:0] clk_state,
  input wire logic slow,
  output logic pll_locked,
  output logic src_ready
);
  logic [4:0] cnt;
  // settle counter; slow mode makes the hold-off observable
  always_ff @(posedge aclk) begin
    if (clk_state == 2'h0) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h1F) begin
      cnt <= cnt + 5'h01;
    end
  end
  assign pll_locked = (clk_state != 2'h0)
    && (cnt >= (slow ? 5'h0C : 5'h02));
  assign src_ready = pll_locked;
endmodule : owcd_osc_model
`default_nettype wire

// *** owcd_pkg.sv ***
// types for the oscillator and watchdog configuration decoder
package owcd_pkg;
  typedef enum logic [2:0] {
    OWCD_SRC_FRC = 3'h0,
    OWCD_SRC_FRC_PLL = 3'h1,
    OWCD_SRC_PRI = 3'h2,
    OWCD_SRC_PRI_PLL = 3'h3,
    OWCD_SRC_SEC = 3'h4,
    OWCD_SRC_LOW_POWER_INTERNAL_RC = 3'h5,
    OWCD_SRC_FRC_DIV16 = 3'h6,
    OWCD_SRC_FRC_POST = 3'h7
  } owcd_src_t;
  typedef enum logic [1:0] {
    OWCD_POSC_EXT = 2'h0,
    OWCD_POSC_XT = 2'h1,
    OWCD_POSC_HS = 2'h2,
    OWCD_POSC_OFF = 2'h3
  } owcd_posc_t;
  typedef enum logic [1:0] {
    OWCD_ST_IDLE = 2'h0,
    OWCD_ST_WAIT_LOCK = 2'h1,
    OWCD_ST_WAIT_READY = 2'h2
  } owcd_st_t;
  // raw configuration words as held in nonvolatile storage
  typedef struct packed {
    logic [7:0] segment_protect_word;
    logic [7:0] osc_select_word;
    logic [7:0] osc_config_word;
    logic [7:0] wdog_config_word;
  } owcd_cfg_t;
  // decoded controls seen by the oscillator and watchdog
  typedef struct packed {
    logic code_write_protect;
    logic two_speed_startup_en;
    owcd_src_t initial_osc_select;
    owcd_src_t active_source;
    logic switch_en;
    logic monitor_en;
    logic osc_out_clock;
    logic osc_out_gpio;
    owcd_posc_t primary_osc_mode;
    logic wdog_run;
    logic low_power_internal_rc_on;
    logic wdog_window_mode;
    logic pll_lock_wait_en;
    logic [7:0] prescale_ratio;
    logic [15:0] postscale_ratio;
  } owcd_ctl_t;
  typedef struct packed {
    owcd_cfg_t cfg;
    owcd_ctl_t ctl;
    owcd_st_t st;
    owcd_src_t pend_src;
    logic sw_wdog_enable;
    logic awv_seen;
    logic [7:0] awaddr_q;
    logic wv_seen;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awready;
    logic wready;
    logic arready;
  } owcd_state_t;
endpackage : owcd_pkg

// *** owcd_top.sv ***
// oscillator and watchdog configuration decoder with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
`include "owcd_consts.svh"
module owcd_top
  import owcd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire owcd_cfg_t nv_cfg,
  input wire logic pll_locked,
  input wire logic src_ready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output owcd_ctl_t ctl,
  output logic [1:0] clk_state
);

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------

  // a source uses the pll when it is one of the two pll selections
  function automatic logic owcd_is_pll(input owcd_src_t s);
    owcd_is_pll = (s == OWCD_SRC_FRC_PLL) || (s == OWCD_SRC_PRI_PLL);
  endfunction : owcd_is_pll

  // full decode of the four configuration words into controls
  function automatic owcd_ctl_t owcd_decode(input owcd_cfg_t c,
      input logic sw_en, input owcd_src_t cur_src);
    owcd_ctl_t d;
    logic [3:0] post;
    d = '0;
    post = c.wdog_config_word[`OWCD_POST_LSB +: 4];
    d.code_write_protect = ~c.segment_protect_word[0]; // R01
    d.two_speed_startup_en = c.osc_select_word[`OWCD_TWO_SPEED_STARTUP_EN_BIT]; // R02
    d.initial_osc_select =
        owcd_src_t'(c.osc_select_word[`OWCD_FNOSC_LSB +: 3]); // R03
    d.active_source = cur_src;
    d.switch_en = ~c.osc_config_word[`OWCD_FCKSM_LSB + 1]; // R05
    d.monitor_en = (c.osc_config_word[`OWCD_FCKSM_LSB +: 2] == 2'h0); // R05
    d.primary_osc_mode =
        owcd_posc_t'(c.osc_config_word[`OWCD_POSC_LSB +: 2]); // R07
    // crystal modes own the output pin, so neither clock nor gpio there
    if (d.primary_osc_mode == OWCD_POSC_XT ||
        d.primary_osc_mode == OWCD_POSC_HS) begin
      d.osc_out_clock = 1'b0;
      d.osc_out_gpio = 1'b0;
    end else begin
      d.osc_out_clock = c.osc_config_word[`OWCD_OSCFN_BIT]; // R06
      d.osc_out_gpio = ~c.osc_config_word[`OWCD_OSCFN_BIT]; // R06
    end
    if (c.wdog_config_word[`OWCD_WDOG_CONFIG_WORD_BIT]) begin
      d.wdog_run = 1'b1; // R08
      d.low_power_internal_rc_on = 1'b1; // R08
    end else begin
      d.wdog_run = sw_en; // R09
      d.low_power_internal_rc_on = sw_en; // R09
    end
    d.wdog_window_mode = ~c.wdog_config_word[`OWCD_WDOG_WINDOW_DISABLE_BIT]; // R10
    d.pll_lock_wait_en = c.wdog_config_word[`OWCD_PLLK_BIT]; // R11
    d.prescale_ratio = c.wdog_config_word[`OWCD_PRE_BIT] ?
        `OWCD_PRE_HI : `OWCD_PRE_LO; // R12
    // power-of-two ladder: 1111 gives 32768, each step down halves
    d.postscale_ratio = 16'h0001 << post; // R13 R14
    owcd_decode = d;
  endfunction : owcd_decode

  owcd_state_t q;
  owcd_state_t next_q;
  owcd_src_t sel;
  logic [31:0] merged;
  logic [7:0] rd_word;
  logic loaded;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------

  // register writes, clock-source sequencer and read path
  always_comb begin
    next_q = q;
    sel = q.ctl.initial_osc_select;
    merged = '0;
    rd_word = 8'h00;

    // bus handshakes: take address and data in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.awv_seen = 1'b1;
      next_q.awaddr_q = s_axi_awaddr;
      next_q.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wv_seen = 1'b1;
      next_q.wdata_q = s_axi_wdata;
      next_q.wstrb_q = s_axi_wstrb;
      next_q.wready = 1'b0;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
    end

    // commit a write once both halves are held
    if (q.awv_seen && q.wv_seen && !q.bvalid) begin
      next_q.awv_seen = 1'b0;
      next_q.wv_seen = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = `OWCD_RESP_OKAY;
      if (q.wstrb_q[0]) begin
        case (q.awaddr_q)
          `OWCD_ADDR_SEGMENT: begin
            next_q.cfg.segment_protect_word = q.wdata_q[7:0];
          end
          `OWCD_ADDR_OSCSEL: begin
            next_q.cfg.osc_select_word = q.wdata_q[7:0];
          end
          `OWCD_ADDR_OSCCFG: begin
            next_q.cfg.osc_config_word = q.wdata_q[7:0];
          end
          `OWCD_ADDR_WDOG: begin
            next_q.cfg.wdog_config_word = q.wdata_q[7:0];
          end
          `OWCD_ADDR_SWCTL: begin
            next_q.sw_wdog_enable = q.wdata_q[0];
          end
          `OWCD_ADDR_STATUS: begin
            next_q.bresp = `OWCD_RESP_OKAY;
          end
          default: begin
            next_q.bresp = `OWCD_RESP_SLVERR;
          end
        endcase
      end else if (q.awaddr_q > `OWCD_ADDR_SWCTL ||
          q.awaddr_q[1:0] != 2'h0) begin
        next_q.bresp = `OWCD_RESP_SLVERR;
      end
    end

    // first edge after reset: every word is reloaded from storage
    if (!loaded) begin
      next_q.cfg = nv_cfg; // R15
    end

    // immediate decode; source select is held while switching is enabled
    next_q.ctl = owcd_decode(next_q.cfg, next_q.sw_wdog_enable,
        q.ctl.active_source); // R15
    // a freshly loaded select is never held back
    if (loaded && q.ctl.switch_en) begin
      next_q.ctl.initial_osc_select = q.ctl.initial_osc_select; // R04
    end
    sel = next_q.ctl.initial_osc_select;

    // sequencer toward the selected source
    case (q.st)
      OWCD_ST_IDLE: begin
        if (sel != q.ctl.active_source) begin
          next_q.pend_src = sel;
          // only a pll target with lock wait on parks in the lock state
          if (owcd_is_pll(sel) && next_q.ctl.pll_lock_wait_en) begin // R11
            next_q.st = OWCD_ST_WAIT_LOCK;
          end else begin
            next_q.st = OWCD_ST_WAIT_READY;
          end
        end
      end
      OWCD_ST_WAIT_LOCK: begin
        // new decode used so state and lock-wait flag move together
        if (!owcd_is_pll(q.pend_src) || !next_q.ctl.pll_lock_wait_en ||
            pll_locked) begin // R11
          next_q.st = OWCD_ST_WAIT_READY;
        end
      end
      OWCD_ST_WAIT_READY: begin
        if (src_ready) begin // R02
          next_q.ctl.active_source = q.pend_src;
          next_q.st = OWCD_ST_IDLE;
        end
      end
      default: begin
        next_q.st = OWCD_ST_IDLE;
      end
    endcase

    // load edge: two-speed start sits on the fast rc, else on the choice
    if (!loaded) begin
      next_q.ctl.active_source = next_q.ctl.two_speed_startup_en ?
          OWCD_SRC_FRC : next_q.ctl.initial_osc_select; // R02
      next_q.st = OWCD_ST_IDLE;
    end

    // read channel, one outstanding read
    if (s_axi_rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = `OWCD_RESP_OKAY;
      case (s_axi_araddr)
        `OWCD_ADDR_SEGMENT: rd_word = q.cfg.segment_protect_word;
        `OWCD_ADDR_OSCSEL: rd_word = q.cfg.osc_select_word;
        `OWCD_ADDR_OSCCFG: rd_word = q.cfg.osc_config_word;
        `OWCD_ADDR_WDOG: rd_word = q.cfg.wdog_config_word;
        `OWCD_ADDR_STATUS: begin
          rd_word = {q.ctl.wdog_run, q.ctl.low_power_internal_rc_on, q.st,
              q.ctl.active_source, 1'b0};
        end
        `OWCD_ADDR_SWCTL: rd_word = {7'h00, q.sw_wdog_enable};
        default: begin
          next_q.rresp = `OWCD_RESP_SLVERR;
        end
      endcase
      merged = {24'h000000, rd_word};
      next_q.rdata = merged;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------

  // reset reloads words from storage one edge after release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.st <= OWCD_ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // storage load happens at the first edge after reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs, taken straight from flip-flops
  // ---------------------------------------------------------------
  owcd_ctl_t ctl_q;
  logic [1:0] st_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= '0;
      st_q <= 2'h0;
    end else begin
      // taken from the next state so the pins line up with the copy in q
      ctl_q <= next_q.ctl;
      st_q <= next_q.st;
    end
  end

  assign ctl = ctl_q;
  assign clk_state = st_q;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

endmodule : owcd_top
`default_nettype wire
